// >>> tlb_lookup_and_page_protection.sv
`timescale 1ns/1ns
`include "tlb_consts.svh"
module tlb_lookup_and_page_protection (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire tlb_pkg::lookup_req_t lookupReq,
  output tlb_pkg::lookup_rsp_t      lookupRsp,
  input  wire tlb_pkg::reg_req_t    regReq,
  output tlb_pkg::reg_rsp_t         regRsp,
  input  wire logic                 loadEntry
);
  import tlb_pkg::*;

  // Set index, shared by lookup and entry load.
  function automatic logic [4:0] calcIndex(input logic [4:0] vpnBits,
                                           input logic [4:0] asidBits,
                                           input logic       hashOn);
    calcIndex = hashOn ? (vpnBits ^ asidBits) : vpnBits;
  endfunction

  // Register address decode, used by read and write paths.
  function automatic reg_sel_t regSelect(input logic [31:0] addr);
    unique case (addr)
      `ADDR_TRANS_CTRL: regSelect = SEL_CTRL;
      `ADDR_ENTRY_HIGH: regSelect = SEL_HIGH;
      `ADDR_ENTRY_LOW:  regSelect = SEL_LOW;
      `ADDR_TABLE_BASE: regSelect = SEL_BASE;
      `ADDR_FAULT_ADDR: regSelect = SEL_FAULT;
      default:          regSelect = SEL_NONE;
    endcase
  endfunction

  // Rights table: privileged reads always pass.
  function automatic logic rightsAllow(input logic [1:0] code,
                                       input logic       priv,
                                       input logic       write);
    unique case (access_rights_t'(code))
      RIGHTS_PRIV_RO: rightsAllow = priv && !write;
      RIGHTS_PRIV_RW: rightsAllow = priv;
      RIGHTS_ALL_RO:  rightsAllow = !write;
      RIGHTS_ALL_RW:  rightsAllow = 1'b1;
    endcase
  endfunction

  // Entry storage: four ways, each of 32 sets.
  tlb_entry_t entryMem [`TLB_WAYS][`TLB_SETS];
  logic [`TLB_WAYS-1:0][`TLB_SETS-1:0] validR;
  logic [`TLB_WAYS-1:0][`TLB_SETS-1:0] validNxt;

  // Control and entry registers.
  logic        enableR;
  logic        enableNxt;
  logic        hashR;
  logic        hashNxt;
  logic        svmR;
  logic        svmNxt;
  logic [1:0]  wayR;
  logic [1:0]  wayNxt;
  logic [21:0] vpnR;
  logic [21:0] vpnNxt;
  logic [7:0]  asidR;
  logic [7:0]  asidNxt;
  logic [31:0] entryLowR;
  logic [31:0] entryLowNxt;
  logic [31:0] tableBaseR;
  logic [31:0] tableBaseNxt;
  logic [31:0] faultAddrR;
  logic [31:0] faultAddrNxt;
  reg_rsp_t    regRspNxt;
  lookup_rsp_t lookupRspNxt;

  // Lookup datapath.
  logic [4:0]           lkIndex;
  logic                 skipAsid;
  tlb_entry_t           readEntry [`TLB_WAYS];
  logic [`TLB_WAYS-1:0] wayHit;
  logic                 hitAny;
  tlb_entry_t           hitEntry;
  logic                 fixedArea;
  logic                 userBad;
  logic                 excEvent;
  logic [1:0]           freeWay;
  logic                 freeAny;

  // Entry load path.
  logic [4:0]  ldIndex;
  tlb_entry_t  ldEntry;
  logic        flushReq;
  reg_sel_t    sel;
  logic        regOk;

  // Read all ways at the chosen set; the valid bits live in flops.
  always_comb begin
    lkIndex  = calcIndex(lookupReq.vaddr[16:12], asidR[4:0], hashR);
    skipAsid = svmR && lookupReq.priv;
    for (int w = 0; w < `TLB_WAYS; w++) begin
      readEntry[w]       = entryMem[w][lkIndex];
      readEntry[w].valid = validR[w][lkIndex];
    end
  end

  // One comparator per way, all working at once.
  generate
    for (genvar g = 0; g < `TLB_WAYS; g++) begin : gWay
      tlb_way_compare uCmp (
        .entry    (readEntry[g]),
        .virtual_page_number      (lookupReq.vaddr[31:10]),
        .address_space_id     (asidR),
        .skipAsid (skipAsid),
        .hit      (wayHit[g])
      );
    end
  endgenerate

  // Pick the hitting way; software keeps hits unique, so lowest wins.
  always_comb begin
    hitAny   = |wayHit;
    hitEntry = readEntry[0];
    for (int w = `TLB_WAYS - 1; w >= 0; w--) begin
      if (wayHit[w]) begin
        hitEntry = readEntry[w];
      end
    end
    freeAny = 1'b0;
    freeWay = 2'h0;
    for (int w = `TLB_WAYS - 1; w >= 0; w--) begin
      if (!readEntry[w].valid) begin
        freeAny = 1'b1;
        freeWay = 2'(w);
      end
    end
  end

  // Lookup result. Priority: address error, bypass, miss, protection,
  // initial write. Protection is checked before the dirty bit so a
  // forbidden write is never reported as a mere first write.
  always_comb begin
    lookupRspNxt = '0;
    fixedArea    = (lookupReq.vaddr[31:30] == `FIXED_AREA_TOP);
    userBad      = !lookupReq.priv && lookupReq.vaddr[31];
    if (lookupReq.valid) begin
      lookupRspNxt.done = 1'b1;
      if (userBad) begin
        lookupRspNxt.addrErr = 1'b1;
      end else if (fixedArea || !enableR) begin
        lookupRspNxt.bypass    = 1'b1;
        lookupRspNxt.cacheable =
          (lookupReq.vaddr[31:29] != `UNCACHED_AREA);
        lookupRspNxt.paddr     = fixedArea ?
          {3'h0, lookupReq.vaddr[28:0]} : lookupReq.vaddr;
      end else if (!hitAny) begin
        lookupRspNxt.miss = 1'b1;
      end else begin
        lookupRspNxt.hit = 1'b1;
        if (!rightsAllow(hitEntry.rights, lookupReq.priv,
                         lookupReq.write)) begin
          lookupRspNxt.protViol = 1'b1;
        end else if (lookupReq.write && !hitEntry.written) begin
          lookupRspNxt.initWrite = 1'b1;
        end else begin
          lookupRspNxt.cacheable = hitEntry.lineFill;
          lookupRspNxt.paddr     = hitEntry.pageSize ?
            {3'h0, hitEntry.ppn[18:2], lookupReq.vaddr[11:0]} :
            {3'h0, hitEntry.ppn, lookupReq.vaddr[9:0]};
        end
      end
    end
    excEvent = lookupRspNxt.addrErr || lookupRspNxt.miss ||
               lookupRspNxt.protViol || lookupRspNxt.initWrite;
  end

  // Entry built from the two staging registers for a load.
  always_comb begin
    ldIndex          = calcIndex(vpnR[6:2], asidR[4:0], hashR);
    ldEntry.virtual_page_number      = vpnR;
    ldEntry.address_space_id     = asidR;
    ldEntry.ppn      = entryLowR[28:`EL_PPN_LSB];
    ldEntry.valid    = entryLowR[`EL_VALID_BIT];
    ldEntry.rights   = entryLowR[`EL_RIGHTS_LSB +: 2];
    ldEntry.pageSize = entryLowR[`EL_SIZE_BIT];
    ldEntry.lineFill = entryLowR[`EL_FILL_BIT];
    ldEntry.written  = entryLowR[`EL_WRITTEN_BIT];
    ldEntry.global   = entryLowR[`EL_GLOBAL_BIT];
  end

  // Register file next state. User mode never reaches the registers,
  // and hardware capture on an exception wins over a software write.
  always_comb begin
    sel          = regSelect(regReq.addr);
    regOk        = regReq.valid && regReq.priv && (sel != SEL_NONE);
    enableNxt    = enableR;
    hashNxt      = hashR;
    svmNxt       = svmR;
    wayNxt       = wayR;
    vpnNxt       = vpnR;
    asidNxt      = asidR;
    entryLowNxt  = entryLowR;
    tableBaseNxt = tableBaseR;
    faultAddrNxt = faultAddrR;
    flushReq     = 1'b0;
    regRspNxt    = '0;
    regRspNxt.ack = regReq.valid;
    regRspNxt.err = regReq.valid && !regOk;
    if (regOk && regReq.write) begin
      unique case (sel)
        SEL_CTRL: begin
          enableNxt = regReq.wdata[`TCR_ENABLE_BIT];
          flushReq  = regReq.wdata[`TCR_FLUSH_BIT];
          wayNxt    = regReq.wdata[`TCR_WAY_LSB +: 2];
          svmNxt    = regReq.wdata[`TCR_SVM_BIT];
          hashNxt   = regReq.wdata[`TCR_HASH_BIT];
        end
        SEL_HIGH: begin
          vpnNxt  = regReq.wdata[31:`EH_VPN_LSB];
          asidNxt = regReq.wdata[`EH_ADDRESS_SPACE_ID_LSB +: 8];
        end
        SEL_LOW:   entryLowNxt  = regReq.wdata & `EL_WRITE_MASK;
        SEL_BASE:  tableBaseNxt = regReq.wdata;
        SEL_FAULT: faultAddrNxt = regReq.wdata;
        SEL_NONE:  ;
      endcase
    end
    if (regOk && !regReq.write) begin
      unique case (sel)
        SEL_CTRL: begin
          regRspNxt.rdata[`TCR_ENABLE_BIT]     = enableR;
          regRspNxt.rdata[`TCR_WAY_LSB +: 2]   = wayR;
          regRspNxt.rdata[`TCR_SVM_BIT]        = svmR;
          regRspNxt.rdata[`TCR_HASH_BIT]       = hashR;
        end
        SEL_HIGH:  regRspNxt.rdata = {vpnR, 2'h0, asidR};
        SEL_LOW:   regRspNxt.rdata = entryLowR;
        SEL_BASE:  regRspNxt.rdata = tableBaseR;
        SEL_FAULT: regRspNxt.rdata = faultAddrR;
        SEL_NONE:  ;
      endcase
    end
    if (excEvent) begin
      vpnNxt       = lookupReq.vaddr[31:10];
      faultAddrNxt = lookupReq.vaddr;
    end
    if (lookupRspNxt.miss) begin
      wayNxt = freeAny ? freeWay : wayR + 2'h1;
    end
  end

  // Valid bits: flush clears all, then a load copies the entry's valid bit into the chosen slot.
  always_comb begin
    validNxt = validR;
    if (flushReq) begin
      validNxt = '0;
    end
    if (loadEntry) begin
      validNxt[wayR][ldIndex] = ldEntry.valid;
    end
  end

  // Enable, hash and way control bits and valid bits are cleared by reset.
  always_ff @(posedge mclk) begin
    if (rst) begin
      enableR   <= `RST_ENABLE;
      hashR     <= `RST_HASH;
      wayR      <= `RST_WAY;
      validR    <= '0;
      regRsp    <= '0;
      lookupRsp <= '0;
    end else begin
      enableR   <= enableNxt;
      hashR     <= hashNxt;
      wayR      <= wayNxt;
      validR    <= validNxt;
      regRsp    <= regRspNxt;
      lookupRsp <= lookupRspNxt;
    end
  end

  // These hold whatever they had: single virtual mode and the four
  // data registers stay undefined through reset, so software sets them.
  always_ff @(posedge mclk) begin
    svmR       <= svmNxt;
    vpnR       <= vpnNxt;
    asidR      <= asidNxt;
    entryLowR  <= entryLowNxt;
    tableBaseR <= tableBaseNxt;
    faultAddrR <= faultAddrNxt;
  end

  // Entry array write; a load lands in the way the control register names.
  always_ff @(posedge mclk) begin
    if (loadEntry) begin
      entryMem[wayR][ldIndex] <= ldEntry;
    end
  end

endmodule // tlb_lookup_and_page_protection

// >>> tlb_consts.svh
// Behaviour
// - Buffer holds four ways of 32 entries, 128 in all, sharing one index.
// - With hashing off, page number bits 16..12 form the set index.
// - With hashing on, index is page bits 16..12 XOR identifier bits 4..0.
// - All four ways at the index are compared in parallel on a lookup.
// - Only an entry whose in-use bit is 1 can hit.
// - Page bits 11..10 are compared for 1 kbyte pages, ignored for 4 kbyte.
// - Identifiers are compared only when the entry is not a global page.
// - Single virtual mode plus privileged access skips identifier comparison.
// - Write to a never-written page raises initial page write; reads pass.
// - A hit reports the entry's line fill bit, cached or uncached access.
// - Rights code 00 priv read, 01 priv rw, 10 read all, 11 all.
// - Access not allowed by the rights code raises a protection violation.
// - Reset clears the control register except single virtual mode.
// - The five registers answer privileged accesses only.
// - Exceptions load the upper 22 address bits into the entry high page.
// - The entry low register changes only by software writes.
// - The table base register is plain storage, never updated by hardware.
// - Fault address register captures the faulting address and holds it.
// - Load entry writes entry high page, identifier and entry low to buffer.
// - The current identifier is an 8-bit field of the entry high register.
// - Fixed mapping areas bypass the buffer, address formed directly.
// - No hitting way at the index signals a buffer miss.
`ifndef TLB_CONSTS_SVH
`define TLB_CONSTS_SVH

`define TLB_WAYS        4
`define TLB_SETS        32
`define TLB_IDX_W       5

`define ADDR_TRANS_CTRL 32'h0fff_ffe0
`define ADDR_ENTRY_HIGH 32'h0fff_fff0
`define ADDR_ENTRY_LOW  32'h0fff_fff4
`define ADDR_TABLE_BASE 32'h0fff_fff8
`define ADDR_FAULT_ADDR 32'h0fff_fffc

`define TCR_ENABLE_BIT  0
`define TCR_FLUSH_BIT   2
`define TCR_WAY_LSB     4
`define TCR_SVM_BIT     8
`define TCR_HASH_BIT    9

`define EH_VPN_LSB      10
`define EH_ADDRESS_SPACE_ID_LSB     0

`define EL_PPN_LSB      10
`define EL_VALID_BIT    8
`define EL_RIGHTS_LSB   5
`define EL_SIZE_BIT     4
`define EL_FILL_BIT     3
`define EL_WRITTEN_BIT  2
`define EL_GLOBAL_BIT   1
`define EL_WRITE_MASK   32'h1fff_fd7e

`define RST_ENABLE      1'h0
`define RST_HASH        1'h0
`define RST_WAY         2'h0

`define FIXED_AREA_TOP  2'h2
`define UNCACHED_AREA   3'h5

`endif

// >>> tlb_pkg.sv
package tlb_pkg;

  // One buffer entry; valid is held apart and merged on read.
  typedef struct packed {
    logic [21:0] virtual_page_number;
    logic [7:0]  address_space_id;
    logic [18:0] ppn;
    logic        valid;
    logic [1:0]  rights;
    logic        pageSize;
    logic        lineFill;
    logic        written;
    logic        global;
  } tlb_entry_t;

  typedef enum logic [1:0] {
    RIGHTS_PRIV_RO = 2'h0,
    RIGHTS_PRIV_RW = 2'h1,
    RIGHTS_ALL_RO  = 2'h2,
    RIGHTS_ALL_RW  = 2'h3
  } access_rights_t;

  typedef enum logic [5:0] {
    SEL_NONE  = 6'h01,
    SEL_CTRL  = 6'h02,
    SEL_HIGH  = 6'h04,
    SEL_LOW   = 6'h08,
    SEL_BASE  = 6'h10,
    SEL_FAULT = 6'h20
  } reg_sel_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        priv;
    logic [31:0] vaddr;
  } lookup_req_t;

  typedef struct packed {
    logic        done;
    logic        bypass;
    logic        hit;
    logic        miss;
    logic        protViol;
    logic        initWrite;
    logic        addrErr;
    logic        cacheable;
    logic [31:0] paddr;
  } lookup_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        priv;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } reg_rsp_t;

endpackage

// >>> tlb_way_compare.sv
`timescale 1ns/1ns
module tlb_way_compare (
  input  wire tlb_pkg::tlb_entry_t entry,
  input  wire logic [21:0]         virtual_page_number,
  input  wire logic [7:0]          address_space_id,
  input  wire logic                skipAsid,
  output logic                     hit
);
  import tlb_pkg::*;

  logic upperEq;
  logic lowEq;
  logic asidEq;

  // Page bits 11..10 only matter for small pages; identifier check is
  // dropped for global pages or when the caller says so.
  always_comb begin
    upperEq = (entry.virtual_page_number[21:2] == virtual_page_number[21:2]);
    lowEq   = entry.pageSize || (entry.virtual_page_number[1:0] == virtual_page_number[1:0]);
    asidEq  = skipAsid || entry.global || (entry.address_space_id == address_space_id);
    hit     = entry.valid && upperEq && lowEq && asidEq;
  end

endmodule // tlb_way_compare

// >>> tlb_checker_properties.sv
`timescale 1ns/1ns
module tlb_checker (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire tlb_pkg::lookup_req_t lookupReq,
  input wire tlb_pkg::lookup_rsp_t lookupRsp,
  input wire tlb_pkg::reg_req_t    regReq,
  input wire tlb_pkg::reg_rsp_t    regRsp,
  input wire logic                 loadEntry
);
  import tlb_pkg::*;

  // Every check runs on the core clock and is muted while reset is held.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // A privileged access into a fixed-mapping area, then its answer.
  sequence sFixedReq;
    lookupReq.valid && lookupReq.priv && lookupReq.vaddr[31:30] == 2'h2;
  endsequence
  sequence sFixedAns;
    sFixedReq ##1 lookupRsp.done;
  endsequence

  a_reg_user_refused:
    assert property (regReq.valid && !regReq.priv |=>
      regRsp.ack && regRsp.err && regRsp.rdata == 32'h0)
    else $error("user register access was not refused");
  a_reg_unmapped:
    assert property (regReq.valid && regReq.addr[31:28] != 4'h0 |=>
      regRsp.ack && regRsp.err)
    else $error("access outside the control area was not refused");
  a_lookup_answer:
    assert property (lookupReq.valid |=> lookupRsp.done)
    else $error("lookup got no answer one cycle later");
  a_idle_silent:
    assert property (!lookupReq.valid && !regReq.valid |=>
      !lookupRsp.done && !regRsp.ack)
    else $error("answer appeared without a request");
  a_one_outcome:
    assert property (lookupRsp.done && !lookupRsp.bypass &&
      !lookupRsp.addrErr |-> lookupRsp.hit != lookupRsp.miss)
    else $error("translated access is neither a single hit nor a miss");
  a_fixed_bypass:
    assert property (sFixedReq |=> lookupRsp.bypass && !lookupRsp.hit &&
      !lookupRsp.miss)
    else $error("fixed-mapping access went through the buffer");
  a_fixed_address:
    assert property (sFixedAns |->
      lookupRsp.paddr == {3'h0, $past(lookupReq.vaddr[28:0])})
    else $error("fixed-mapping physical address is wrong");
  a_viol_no_init:
    assert property (lookupRsp.done && lookupRsp.protViol |->
      lookupRsp.hit && !lookupRsp.initWrite)
    else $error("protection violation reported with initial write");
  a_read_no_init:
    assert property (lookupReq.valid && !lookupReq.write |=>
      !lookupRsp.initWrite)
    else $error("read raised an initial page write");
endmodule // tlb_checker

bind tlb_lookup_and_page_protection tlb_checker tlb_checker_inst (
  .mclk(mclk), .rst(rst), .lookupReq(lookupReq), .lookupRsp(lookupRsp),
  .regReq(regReq), .regRsp(regRsp), .loadEntry(loadEntry));

// >>> core_pipe_model.sv
`timescale 1ns/1ns
module core_pipe_model (
  input  wire logic                 mclk,
  output tlb_pkg::lookup_req_t      lookupReq,
  input  wire tlb_pkg::lookup_rsp_t lookupRsp,
  output tlb_pkg::reg_req_t         regReq,
  input  wire tlb_pkg::reg_rsp_t    regRsp,
  output logic                      loadEntry
);
  import tlb_pkg::*;

  // Idle lines carry junk so the block cannot lean on stale fields.
  initial begin
    lookupReq = '{1'b0, 1'b0, 1'b0, 32'h5a5a_5a5a};
    regReq = '{1'b0, 1'b0, 1'b0, 32'ha5a5_a5a5, 32'h5a5a_5a5a};
    loadEntry = 1'b0;
  end

  // One load or store; the answer is taken one cycle after the request.
  task automatic lookup(input logic [31:0] va, input logic w, p,
                        output lookup_rsp_t r);
    @(posedge mclk);
    lookupReq <= '{1'b1, w, p, va};
    @(posedge mclk);
    lookupReq <= '{1'b0, ~w, ~p, ~va};
    #1 r = lookupRsp;
  endtask

  // One control-area word access, privileged or not.
  task automatic regAcc(input logic [31:0] a, input logic w, p,
                        input logic [31:0] d, output reg_rsp_t r);
    @(posedge mclk);
    regReq <= '{1'b1, w, p, a, d};
    @(posedge mclk);
    regReq <= '{1'b0, ~w, ~p, ~a, ~d};
    #1 r = regRsp;
  endtask

  // The load-entry instruction lasts exactly one cycle.
  task automatic loadPulse();
    @(posedge mclk);
    loadEntry <= 1'b1;
    @(posedge mclk);
    loadEntry <= 1'b0;
  endtask
endmodule // core_pipe_model

// >>> tb_top.sv
`timescale 1ns/1ns
`include "tlb_consts.svh"
module tb_top;
  import tlb_pkg::*;
  // Flag order, top down: address error, hit, miss, protection,
  // initial write, bypass.
  localparam logic [5:0]  HIT = 6'h10, MISS = 6'h08, PV = 6'h14;
  localparam logic [5:0]  IW = 6'h12, BYP = 6'h01, AE = 6'h20;
  localparam logic [31:0] LOW = 32'h0abc_d17c;
  localparam logic [15:0] OKMAP = 16'hf5c4;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        loadEntry;
  lookup_req_t lookupReq;
  lookup_rsp_t lookupRsp;
  reg_req_t    regReq;
  reg_rsp_t    regRsp;
  logic [31:0] rv;
  logic [31:0] pa;
  logic        ca;
  int          n_fail = 0;
  int          n_compared = 0;

  // Core clock, 4 ns period.
  always #2 mclk = ~mclk;

  tlb_lookup_and_page_protection tlb_lookup_and_page_protection_inst (
    .mclk(mclk), .rst(rst), .lookupReq(lookupReq), .lookupRsp(lookupRsp),
    .regReq(regReq), .regRsp(regRsp), .loadEntry(loadEntry));
  core_pipe_model core_pipe_model_inst (
    .mclk(mclk), .lookupReq(lookupReq), .lookupRsp(lookupRsp),
    .regReq(regReq), .regRsp(regRsp), .loadEntry(loadEntry));

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Privileged or user word access; the error flag is always judged.
  task automatic reg1(input logic [31:0] a, d, input logic w, p, e);
    reg_rsp_t r;
    core_pipe_model_inst.regAcc(a, w, p, d, r);
    check("register answer", {30'h0, r.ack, r.err}, {30'h0, 1'b1, e});
    rv = r.rdata;
  endtask

  // Flushing before each load keeps any two ways from matching.
  task automatic setEntry(input logic [31:0] c, h, l);
    reg1(`ADDR_TRANS_CTRL, c, 1'b1, 1'b1, 1'b0);
    reg1(`ADDR_ENTRY_HIGH, h, 1'b1, 1'b1, 1'b0);
    reg1(`ADDR_ENTRY_LOW, l, 1'b1, 1'b1, 1'b0);
    core_pipe_model_inst.loadPulse();
  endtask

  // Every lookup must be answered, so the done flag is judged as well.
  task automatic acc(input logic [31:0] va, input logic w, p,
                     input logic [5:0] e);
    lookup_rsp_t r;
    core_pipe_model_inst.lookup(va, w, p, r);
    check("lookup flags", {25'h0, r.done, r.addrErr, r.hit, r.miss,
      r.protViol, r.initWrite, r.bypass}, {25'h0, 1'b1, e});
    pa = r.paddr;
    ca = r.cacheable;
  endtask

  task automatic testRegs();
    reg1(`ADDR_TRANS_CTRL, 32'h0, 1'b0, 1'b1, 1'b0);
    check("control reset", rv & 32'hffff_feff, 32'h0);
    reg1(`ADDR_TABLE_BASE, 32'h1234_5678, 1'b1, 1'b1, 1'b0);
    reg1(`ADDR_TABLE_BASE, 32'hffff_ffff, 1'b1, 1'b0, 1'b1);
    reg1(`ADDR_TABLE_BASE, 32'h0, 1'b0, 1'b1, 1'b0);
    check("table base", rv, 32'h1234_5678);
    reg1(`ADDR_ENTRY_LOW, 32'hffff_ffff, 1'b1, 1'b1, 1'b0);
    reg1(32'h0fff_ffe4, 32'h0, 1'b0, 1'b1, 1'b1);
    reg1(32'hffff_fff0, 32'h0, 1'b0, 1'b1, 1'b1);
    $display("registers done");
  endtask

  task automatic testMiss();
    setEntry(32'h5, 32'h0000_5012, LOW & 32'hffff_feff);
    acc(32'h0000_5400, 1'b0, 1'b1, MISS);
    reg1(`ADDR_FAULT_ADDR, 32'h0, 1'b0, 1'b1, 1'b0);
    check("fault address", rv, 32'h0000_5400);
    reg1(`ADDR_ENTRY_HIGH, 32'h0, 1'b0, 1'b1, 1'b0);
    check("entry high page", rv & 32'hffff_fc00, 32'h0000_5400);
    reg1(`ADDR_ENTRY_LOW, 32'h0, 1'b0, 1'b1, 1'b0);
    check("entry low", rv, LOW & 32'h1fff_fe7e);
    $display("miss done");
  endtask

  task automatic testHit();
    setEntry(32'h5, 32'h0000_5012, LOW);
    acc(32'h0000_5abc, 1'b1, 1'b0, HIT);
    check("paddr 4k", pa, 32'h0abc_dabc);
    check("cached", {31'h0, ca}, 32'h1);
    acc(32'h0000_5c00, 1'b0, 1'b1, HIT);
    setEntry(32'h5, 32'h0000_5012, LOW & 32'hffff_ffe7);
    acc(32'h0000_53ff, 1'b0, 1'b1, HIT);
    check("paddr 1k", pa, 32'h0abc_d3ff);
    check("uncached", {31'h0, ca}, 32'h0);
    acc(32'h0000_5400, 1'b0, 1'b1, MISS);
    $display("hit done");
  endtask

  task automatic testAsid();
    setEntry(32'h5, 32'h0000_5012, LOW);
    reg1(`ADDR_ENTRY_HIGH, 32'h0000_5013, 1'b1, 1'b1, 1'b0);
    acc(32'h0000_5000, 1'b0, 1'b1, MISS);
    reg1(`ADDR_TRANS_CTRL, 32'h0000_0101, 1'b1, 1'b1, 1'b0);
    acc(32'h0000_5000, 1'b0, 1'b1, HIT);
    acc(32'h0000_5000, 1'b0, 1'b0, MISS);
    setEntry(32'h5, 32'h0000_5012, LOW | 32'h2);
    reg1(`ADDR_ENTRY_HIGH, 32'h0000_5013, 1'b1, 1'b1, 1'b0);
    acc(32'h0000_5000, 1'b0, 1'b0, HIT);
    setEntry(32'h0000_0205, 32'h0000_5003, LOW);
    acc(32'h0000_5000, 1'b0, 1'b1, HIT);
    reg1(`ADDR_TRANS_CTRL, 32'h1, 1'b1, 1'b1, 1'b0);
    acc(32'h0000_5000, 1'b0, 1'b1, MISS);
    $display("identifier and index done");
  endtask

  // Every rights code against both modes and both directions.
  task automatic testRights();
    for (int r = 0; r < 4; r++) begin
      setEntry(32'h5, 32'h0000_5012, (LOW & 32'hffff_ff9f) | (32'(r) << 5));
      for (int k = 0; k < 4; k++) begin
        acc(32'h0000_5000, k[0], k[1], OKMAP[r*4+k] ? HIT : PV);
      end
    end
    setEntry(32'h5, 32'h0000_5012, LOW & 32'hffff_fffb);
    acc(32'h0000_5000, 1'b1, 1'b1, IW);
    acc(32'h0000_5000, 1'b1, 1'b0, IW);
    acc(32'h0000_5000, 1'b0, 1'b0, HIT);
    $display("rights done");
  endtask

  task automatic testBypass();
    acc(32'h8000_1234, 1'b1, 1'b1, BYP);
    check("fixed paddr", pa, 32'h0000_1234);
    acc(32'ha000_1234, 1'b0, 1'b1, BYP);
    check("uncached area", {31'h0, ca}, 32'h0);
    // A user access to the upper half is an address error and is logged.
    acc(32'h8000_1234, 1'b0, 1'b0, AE);
    reg1(`ADDR_FAULT_ADDR, 32'h0, 1'b0, 1'b1, 1'b0);
    check("error fault address", rv, 32'h8000_1234);
    reg1(`ADDR_ENTRY_HIGH, 32'h0, 1'b0, 1'b1, 1'b0);
    check("error entry page", rv & 32'hffff_fc00, 32'h8000_1000);
    $display("bypass done");
  endtask

  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    testRegs();
    testMiss();
    testHit();
    testAsid();
    testRights();
    testBypass();
    report_and_stop();
  end

  // A hang is cut short and counted as a mismatch.
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end
endmodule // tb_top
